// ---- common/oev_defs.svh ----
// offsets, field positions, reset values for the line and supply control bank
`ifndef OEV_DEFS_SVH
`define OEV_DEFS_SVH

// register addresses (6-bit register space)
`define OEV_ADDR_W 6
`define OEV_CTRL_BASE 6'h0A
`define OEV_RISE_BASE 6'h0D
`define OEV_FALL_BASE 6'h10
`define OEV_STAT_ADDR 6'h13
`define OEV_LATCH_ADDR 6'h14

// offsets of the set and clear aliases from a base address
`define OEV_SET_OFS 6'h01
`define OEV_CLR_OFS 6'h02

// control register fields
`define OEV_B_ID_PULLUP 0
`define OEV_B_DP_PULLDOWN 1
`define OEV_B_DM_PULLDOWN 2
`define OEV_B_DISCHARGE 3
`define OEV_B_CHARGE 4
`define OEV_B_DRIVE 5
`define OEV_B_DRIVE_ALT 6
`define OEV_B_OK_SEL 7

// event source fields, shared by enables, status and latch
`define OEV_B_HOST_DISC 0
`define OEV_B_SUPPLY_OK 1
`define OEV_B_SESS_OK 2
`define OEV_B_SESS_OVER 3
`define OEV_B_ID_LOW 4
`define OEV_SRC_W 5

// reset values and writable masks
`define OEV_CTRL_RST 8'h06
`define OEV_CTRL_MASK 8'hFF
`define OEV_EDGE_RST 8'h1F
`define OEV_EDGE_MASK 8'h1F
`define OEV_ZERO_BYTE 8'h00

// external supply indicator is hard-wired high on this device
`define OEV_EXT_IND_LEVEL 1'b1

`endif

// ---- common/oev_pkg.sv ----
// types shared by the line and supply control bank
package oev_pkg;

    typedef logic [7:0] oev_byte_t;

    // one bit per event source, bit 4 first, bit 0 last
    typedef struct packed {
        logic ident_pin_low;
        logic session_over;
        logic session_ok;
        logic supply_ok;
        logic host_disc;
    } oev_src_s;

    // one register access from the link side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } oev_req_s;

    // pin-level controls toward the analog front end
    typedef struct packed {
        logic ident_pin_pullup_en;
        logic dplus_pulldown_en;
        logic dminus_pulldown_en;
        logic supply_discharge_en;
        logic supply_charge_en;
        logic charge_pump_enable_out;
    } oev_pins_s;

endpackage

// ---- hdl/oev_wsc_reg.sv ----
// one byte register with write, set and clear aliases
`timescale 1ns/10ps
`default_nettype none

`include "oev_defs.svh"

module oev_wsc_reg
    import oev_pkg::*;
#(
    parameter logic [5:0] BASE = `OEV_CTRL_BASE,
    parameter logic [7:0] RST = `OEV_ZERO_BYTE,
    parameter logic [7:0] MASK = `OEV_CTRL_MASK
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire oev_req_s i_req,
    output logic o_hit,
    output oev_byte_t o_q
);

    oev_byte_t q_r;
    oev_byte_t q_nxt;
    logic wr_hit;
    logic set_hit;
    logic clr_hit;

    assign wr_hit = i_req.wr && (i_req.addr == BASE);
    assign set_hit = i_req.wr && (i_req.addr == BASE + `OEV_SET_OFS);
    assign clr_hit = i_req.wr && (i_req.addr == BASE + `OEV_CLR_OFS);
    assign o_hit = (i_req.addr == BASE)
        || (i_req.addr == BASE + `OEV_SET_OFS)
        || (i_req.addr == BASE + `OEV_CLR_OFS);
    assign o_q = q_r;

    always_comb
    begin
        q_nxt = q_r;
        if (wr_hit)
        begin
            q_nxt = i_req.wdata & MASK;
        end
        else if (set_hit)
        begin
            q_nxt = q_r | (i_req.wdata & MASK);
        end
        else if (clr_hit)
        begin
            q_nxt = q_r & ~(i_req.wdata & MASK);
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            q_r <= RST;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- hdl/oev_bank.sv ----
// line and supply control bank with edge event enables, status and latch
//
// Operation
// - control byte: read range, write/set/clear aliases
// - bit 0 ident pull-up, resets 0
// - bits 1,2 data-line pull-downs, reset 1
// - bit 3 supply discharge path, resets 0
// - bit 4 supply charge path, resets 0
// - pump enable is OR of bits 5,6
// - bit 7 picks supply-ok source
// - external supply indicator always high
// - rising enables: read range, write/set/clear
// - rising enable bits 0-4, reset 1
// - falling enables: read range, write/set/clear
// - falling enable bits 0-4, reset 1
// - host disconnect meaningful only in host mode
// - status read-only, shows live sources
// - status bits 0-4, zero after reset
// - supply-ok, session-over read 0 if both enabled
// - session-ok status always live
// - status sampled at moment of read
// - enabled edge sets latch; read clears it
`timescale 1ns/10ps
`default_nettype none

`include "oev_defs.svh"

module oev_bank
    import oev_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire oev_req_s i_reg_req,
    input wire oev_src_s i_src,
    input wire logic i_host_mode,
    output oev_byte_t o_reg_rdata,
    output logic o_reg_rvalid,
    output oev_pins_s o_pins,
    output logic o_event_pending
);

    ////////////////////////////////////////////////////////////////////////
    // register file
    // each alias decode lives inside its own register instance

    oev_byte_t ctrl_q;
    oev_byte_t rise_q;
    oev_byte_t fall_q;
    logic ctrl_hit;
    logic rise_hit;
    logic fall_hit;

    // control byte: pulls, supply paths, drive, ok-source select
    oev_wsc_reg #(
        .BASE(`OEV_CTRL_BASE),
        .RST(`OEV_CTRL_RST),
        .MASK(`OEV_CTRL_MASK)
    ) u_ctrl_reg (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_req(i_reg_req),
        .o_hit(ctrl_hit),
        .o_q(ctrl_q)
    );

    // rising-edge enables
    oev_wsc_reg #(
        .BASE(`OEV_RISE_BASE),
        .RST(`OEV_EDGE_RST),
        .MASK(`OEV_EDGE_MASK)
    ) u_rise_reg (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_req(i_reg_req),
        .o_hit(rise_hit),
        .o_q(rise_q)
    );

    // falling-edge enables
    oev_wsc_reg #(
        .BASE(`OEV_FALL_BASE),
        .RST(`OEV_EDGE_RST),
        .MASK(`OEV_EDGE_MASK)
    ) u_fall_reg (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_req(i_reg_req),
        .o_hit(fall_hit),
        .o_q(fall_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // source conditioning

    logic ext_indicator;
    logic supply_ok_live;
    logic host_disc_live;
    oev_src_s src_live;

    assign ext_indicator = `OEV_EXT_IND_LEVEL;

    always_comb
    begin
        // bit 7 steers where the supply-ok level comes from
        if (ctrl_q[`OEV_B_OK_SEL])
        begin
            supply_ok_live = ext_indicator;
        end
        else
        begin
            supply_ok_live = i_src.supply_ok;
        end
        // outside host mode the disconnect detector means nothing
        host_disc_live = i_host_mode & i_src.host_disc;
        src_live.host_disc = host_disc_live;
        src_live.supply_ok = supply_ok_live;
        src_live.session_ok = i_src.session_ok;
        src_live.session_over = i_src.session_over;
        src_live.ident_pin_low = i_src.ident_pin_low;
    end

    ////////////////////////////////////////////////////////////////////////
    // edge detection

    oev_src_s src_prev_r;
    oev_src_s src_prev_nxt;
    logic primed_r;
    logic primed_nxt;
    logic [`OEV_SRC_W-1:0] rise_evt;
    logic [`OEV_SRC_W-1:0] fall_evt;
    logic [`OEV_SRC_W-1:0] rise_mask;
    logic [`OEV_SRC_W-1:0] fall_mask;

    // only bits 4:0 of each enable byte are implemented
    assign rise_mask = rise_q[`OEV_SRC_W-1:0];
    assign fall_mask = fall_q[`OEV_SRC_W-1:0];

    always_comb
    begin
        src_prev_nxt = src_live;
        primed_nxt = 1'b1;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            src_prev_r <= '0;
            primed_r <= 1'b0;
        end
        else
        begin
            src_prev_r <= src_prev_nxt;
            primed_r <= primed_nxt;
        end
    end

    // the first sample after reset only primes the history, no events
    always_comb
    begin
        rise_evt = '0;
        fall_evt = '0;
        if (primed_r)
        begin
            rise_evt = src_live & ~src_prev_r & rise_mask;
            fall_evt = ~src_live & src_prev_r & fall_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event latch, cleared by reading it

    logic [`OEV_SRC_W-1:0] latch_r;
    logic [`OEV_SRC_W-1:0] latch_nxt;
    logic latch_rd;
    logic pending_r;
    logic pending_nxt;

    // the read that clears the latch still returns its old value
    assign latch_rd = i_reg_req.rd
        && (i_reg_req.addr == `OEV_LATCH_ADDR);

    always_comb
    begin
        latch_nxt = latch_r;
        if (latch_rd)
        begin
            latch_nxt = '0;
        end
        // an edge in the clearing cycle survives the clear
        latch_nxt = latch_nxt | rise_evt | fall_evt;
        pending_nxt = |latch_nxt;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            latch_r <= '0;
            pending_r <= 1'b0;
        end
        else
        begin
            latch_r <= latch_nxt;
            pending_r <= pending_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status view

    oev_byte_t status_view;

    // a read in the priming cycle still returns the reset default
    always_comb
    begin
        status_view = `OEV_ZERO_BYTE;
        if (primed_r)
        begin
            status_view[`OEV_B_HOST_DISC] = src_live.host_disc;
            status_view[`OEV_B_SUPPLY_OK] = src_live.supply_ok
                & ~(rise_q[`OEV_B_SUPPLY_OK]
                & fall_q[`OEV_B_SUPPLY_OK]);
            status_view[`OEV_B_SESS_OK] = src_live.session_ok;
            status_view[`OEV_B_SESS_OVER] = src_live.session_over
                & ~(rise_q[`OEV_B_SESS_OVER]
                & fall_q[`OEV_B_SESS_OVER]);
            status_view[`OEV_B_ID_LOW] = src_live.ident_pin_low;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port

    oev_byte_t rdata_r;
    oev_byte_t rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic stat_rd;

    // status is taken from the live view at the read edge
    assign stat_rd = i_reg_req.rd
        && (i_reg_req.addr == `OEV_STAT_ADDR);

    always_comb
    begin
        rdata_nxt = rdata_r;
        rvalid_nxt = i_reg_req.rd;
        if (i_reg_req.rd)
        begin
            if (ctrl_hit)
            begin
                rdata_nxt = ctrl_q;
            end
            else if (rise_hit)
            begin
                rdata_nxt = rise_q;
            end
            else if (fall_hit)
            begin
                rdata_nxt = fall_q;
            end
            else if (stat_rd)
            begin
                rdata_nxt = status_view;
            end
            else if (latch_rd)
            begin
                rdata_nxt = {3'h0, latch_r};
            end
            else
            begin
                rdata_nxt = `OEV_ZERO_BYTE;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            rdata_r <= `OEV_ZERO_BYTE;
            rvalid_r <= 1'b0;
        end
        else
        begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    oev_pins_s pins_r;
    oev_pins_s pins_nxt;

    // reset levels come from the control byte's reset value
    localparam oev_byte_t CTRL_RST = `OEV_CTRL_RST;

    always_comb
    begin
        // one register stage between control byte and pins
        pins_nxt.ident_pin_pullup_en = ctrl_q[`OEV_B_ID_PULLUP];
        pins_nxt.dplus_pulldown_en = ctrl_q[`OEV_B_DP_PULLDOWN];
        pins_nxt.dminus_pulldown_en = ctrl_q[`OEV_B_DM_PULLDOWN];
        pins_nxt.supply_discharge_en = ctrl_q[`OEV_B_DISCHARGE];
        pins_nxt.supply_charge_en = ctrl_q[`OEV_B_CHARGE];
        pins_nxt.charge_pump_enable_out = ctrl_q[`OEV_B_DRIVE]
            | ctrl_q[`OEV_B_DRIVE_ALT];
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_rst_n)
        begin
            pins_r.ident_pin_pullup_en <= CTRL_RST[`OEV_B_ID_PULLUP];
            pins_r.dplus_pulldown_en <= CTRL_RST[`OEV_B_DP_PULLDOWN];
            pins_r.dminus_pulldown_en <= CTRL_RST[`OEV_B_DM_PULLDOWN];
            pins_r.supply_discharge_en <= CTRL_RST[`OEV_B_DISCHARGE];
            pins_r.supply_charge_en <= CTRL_RST[`OEV_B_CHARGE];
            pins_r.charge_pump_enable_out <= CTRL_RST[`OEV_B_DRIVE]
                | CTRL_RST[`OEV_B_DRIVE_ALT];
        end
        else
        begin
            pins_r <= pins_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_reg_rdata = rdata_r;
    assign o_reg_rvalid = rvalid_r;
    assign o_pins = pins_r;
    assign o_event_pending = pending_r;

endmodule

`default_nettype wire

// ---- tb/oev_bank_chk.sv ----
// port assertions for the line and supply control bank
`timescale 1ns/10ps
`default_nettype none

module oev_bank_chk
    import oev_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire oev_req_s i_reg_req,
    input wire oev_src_s i_src,
    input wire logic i_host_mode,
    input wire oev_byte_t o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire oev_pins_s o_pins,
    input wire logic o_event_pending
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    logic st_rd;
    assign st_rd = i_reg_req.rd && i_reg_req.addr == 6'h13;

    property p_rvalid;
        o_reg_rvalid == $past(i_reg_req.rd);
    endproperty
    property p_ctrl_pins;
        oev_byte_t v;
        (i_reg_req.wr && i_reg_req.addr == 6'h0A, v = i_reg_req.wdata)
            |-> ##2 o_pins == {v[0], v[1], v[2], v[3], v[4], v[5] | v[6]};
    endproperty
    property p_rsvd;
        i_reg_req.rd && i_reg_req.addr inside {[6'h0D:6'h14]}
            |=> o_reg_rdata[7:5] == 3'h0;
    endproperty
    property p_unmapped;
        i_reg_req.rd && !(i_reg_req.addr inside {[6'h0A:6'h14]})
            |=> o_reg_rdata == 8'h00;
    endproperty
    property p_sess_ok;
        st_rd && $past(i_rst_n) |=> o_reg_rdata[2] == $past(i_src.session_ok);
    endproperty
    property p_host_gate;
        st_rd && !i_host_mode |=> o_reg_rdata[0] == 1'b0;
    endproperty
    property p_id_low;
        st_rd && $past(i_rst_n)
            |=> o_reg_rdata[4] == $past(i_src.ident_pin_low);
    endproperty
    property p_reset;
        disable iff (1'b0)
        !i_rst_n |=> o_pins == 6'h18 && !o_reg_rvalid && !o_event_pending
            && o_reg_rdata == 8'h00;
    endproperty

    a_rvalid: assert property (p_rvalid)
        else $error("read valid not one cycle after read");
    a_ctrl_pins: assert property (p_ctrl_pins)
        else $error("pins do not follow control write");
    a_rsvd: assert property (p_rsvd)
        else $error("reserved bits not zero");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_sess_ok: assert property (p_sess_ok)
        else $error("session ok status not live");
    a_host_gate: assert property (p_host_gate)
        else $error("host disconnect seen outside host mode");
    a_id_low: assert property (p_id_low)
        else $error("ident low status not live");
    a_reset: assert property (p_reset)
        else $error("reset values wrong");

    c_ctrl_wr: cover property (i_reg_req.wr && i_reg_req.addr == 6'h0A);
    c_stat_rd: cover property (st_rd ##1 o_reg_rvalid);
    c_pending: cover property (o_event_pending);
endmodule

`default_nettype wire

// ---- tb/oev_link_model.sv ----
// link-side register access model for the bank's strobe port
`timescale 1ns/10ps
`default_nettype none

module oev_link_model
    import oev_pkg::*;
(
    input wire logic i_core_clk,
    output var oev_req_s o_req
);
    initial o_req = '0;

    task automatic access(input logic w, input logic [5:0] a,
                          input oev_byte_t d);
        @(negedge i_core_clk);
        o_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_core_clk);
        // released lines show the inverse of the last value
        o_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
endmodule

`default_nettype wire

// ---- tb/oev_bank_bench.sv ----
// self-checking bench for the line and supply control bank
`timescale 1ns/10ps
`default_nettype none

module oev_bank_bench
    import oev_pkg::*;
;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    oev_req_s req;
    oev_src_s src = '0;
    logic host = 1'b0;
    oev_byte_t rdata;
    logic rvalid;
    oev_pins_s pins;
    logic pending;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    oev_byte_t ctl, rise, fall, m, v, s, c;
    logic [5:0] b;

    always #10 i_core_clk = ~i_core_clk;

    oev_bank i_dut (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_reg_req(req),
        .i_src(src),
        .i_host_mode(host),
        .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid),
        .o_pins(pins),
        .o_event_pending(pending)
    );
    oev_link_model i_link (.i_core_clk(i_core_clk), .o_req(req));

    task automatic check(input oev_byte_t got, input oev_byte_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_pins(input oev_byte_t d);
        check({2'h0, pins}, {2'h0, d[0], d[1], d[2], d[3], d[4], d[5] | d[6]});
    endtask
    task automatic wr(input logic [5:0] a, input oev_byte_t d);
        i_link.access(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input oev_byte_t mk,
                      input oev_byte_t d);
        exp_q.push_back({mk, d});
        i_link.access(1'b0, a, 8'h00);
    endtask
    function automatic oev_byte_t stat_exp();
        logic ok;
        ok = ctl[7] ? 1'b1 : src.supply_ok;
        return {3'h0, src.ident_pin_low,
            src.session_over & ~(rise[3] & fall[3]),
            src.session_ok, ok & ~(rise[1] & fall[1]), src.host_disc & host};
    endfunction
    task automatic test_done();
        if (exp_q.size() != 0)
            err_total++;
        $display("compares %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // read results are matched against the oldest note
    always @(negedge i_core_clk)
        if (rvalid === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check(rdata & e[15:8], e[7:0]);
        end
        else if (rvalid === 1'b1)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rdata, 8'h00);
        end

    always @(posedge i_core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            err_total++;
            test_done();
        end
    end

    initial
    begin
        void'($urandom(32'h0153));
        repeat (16) @(posedge i_core_clk);
        @(negedge i_core_clk);
        i_rst_n = 1'b1;
        check_pins(8'h06);
        for (int a = 10; a < 19; a++)
            rd(6'(a), 8'hFF, (a < 13) ? 8'h06 : 8'h1F);
        wr(6'h13, 8'hFF);
        rd(6'h13, 8'hFF, 8'h00);
        rd(6'h20, 8'hFF, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            b = 6'h0A + 6'(3 * i);
            m = (i == 0) ? 8'hFF : 8'h1F;
            v = 8'($urandom);
            s = 8'($urandom);
            c = 8'($urandom);
            wr(b, v);
            wr(b + 6'h01, s);
            wr(b + 6'h02, c);
            rd(b + 6'h02, 8'hFF, (v | s) & ~c & m);
        end
        for (int k = 0; k < 5; k++)
        begin
            v = (k == 0) ? 8'h20 : (k == 1) ? 8'h40 : (k == 2) ? 8'h60
                : (k == 3) ? 8'h9F : 8'h00;
            wr(6'h0A, v);
            repeat (2) @(negedge i_core_clk);
            check_pins(v);
        end
        for (int i = 0; i < 8; i++)
        begin
            ctl = 8'($urandom) & 8'h80;
            rise = (i == 0) ? 8'h1F : 8'($urandom) & 8'h1F;
            fall = (i == 0) ? 8'h1F : 8'($urandom) & 8'h1F;
            wr(6'h0A, ctl);
            wr(6'h0D, rise);
            wr(6'h10, fall);
            src = 5'($urandom);
            host = 1'($urandom);
            rd(6'h13, 8'hFF, stat_exp());
        end
        wr(6'h0A, 8'h00);
        src = '0;
        host = 1'b0;
        wr(6'h0D, 8'h1F);
        wr(6'h10, 8'h1F);
        rd(6'h14, 8'h00, 8'h00);
        wr(6'h0F, 8'h04);
        src.session_ok = 1'b1;
        src.ident_pin_low = 1'b1;
        repeat (3) @(negedge i_core_clk);
        check({7'h00, pending}, 8'h01);
        rd(6'h14, 8'hFF, 8'h10);
        rd(6'h14, 8'hFF, 8'h00);
        repeat (3) @(negedge i_core_clk);
        check({7'h00, pending}, 8'h00);
        test_done();
    end
endmodule

bind oev_bank oev_bank_chk i_chk (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_reg_req(i_reg_req),
    .i_src(i_src),
    .i_host_mode(i_host_mode),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .o_pins(o_pins),
    .o_event_pending(o_event_pending)
);

`default_nettype wire
